// >>> logic/rtcc_core.sv
// Real-time clock timekeeping core with byte-wide I/O register access
//
// Contract
// [RULE_01] Power-up: counts undefined, alarms disabled
// [RULE_02] Software unlocks, loads time, alarms, relocks
// [RULE_03] Clearing unlock restarts the prescaler
// [RULE_04] Unlocked: counting stops, counts writable
// [RULE_05] Locked: counting runs, count writes ignored
// [RULE_06] Reset leaves the counter locked
// [RULE_07] Registers are byte-wide I/O locations
// [RULE_08] Counts survive reset untouched
// [RULE_09] BCD enable selects packed BCD or binary
// [RULE_10] Seconds run 0 to 59
// [RULE_11] Minutes run 0 to 59
// [RULE_12] Hours run 0 to 23
// [RULE_13] Weekday 1 to 7, upper nibble zero
// [RULE_14] Day of month starts at one
// [RULE_15] Per-second advance, alarm on enabled match
// [RULE_16] Month length kept, leap year only BCD
// [RULE_17] Control write resets the prescaler
// [RULE_18] Month runs 1 to 12, takes day carry
// [RULE_19] Counts wrap and carry upward
module rtcc_core #(
	parameter int XTAL_DIV = rtcc_pkg::DIV_XTAL
) (
	// Clock, reset, enable
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic clk_en_i,
	// Time source pin: 32 kHz oscillator or mains
	input wire logic src_clk_i,
	// CPU I/O bus
	input wire logic [15:0] io_addr_i,
	input wire logic io_rd_i,
	input wire logic io_wr_i,
	input wire logic [7:0] io_wdata_i,
	output logic [7:0] io_rdata_o,
	// Alarm flag
	output logic alarm_o
);
	rtcc_pkg::rtcc_time_type cnt_q, cnt_d;
	rtcc_pkg::rtcc_alarm_type aset_q, aset_d;
	logic [3:0] aen_q, aen_d;
	logic unlock_q, unlock_d, clk_sel_q, clk_sel_d;
	logic line60_q, line60_d, bcd_q, bcd_d;
	logic alarm_q, alarm_d, cmp_q, cmp_d;
	logic [15:0] presc_q, presc_d;
	logic [2:0] src_q;
	logic [7:0] rdata_q, rdata_d;
	logic src_edge, sec_tick, ctrl_wr, cnt_wr, match;
	logic [15:0] div_top;

	// Wrap-or-step a count; bit 8 is the carry out
	function automatic logic [8:0] step(input logic [7:0] v,
			input logic [7:0] lo, input logic [7:0] hi, input logic bcd);
		if (v == hi)
			step = {1'b1, lo}; // [RULE_19]
		else if (bcd && v[3:0] == 4'h9)
			step = {1'b0, v[7:4] + 4'h1, 4'h0}; // [RULE_09]
		else
			step = {1'b0, v + 8'h01};
	endfunction

	// Last day of the month in the active encoding
	function automatic logic [7:0] month_end(input logic [7:0] mon,
			input logic [7:0] yr, input logic bcd);
		logic [3:0] m;
		logic leap;
		m = bcd ? (mon[7:4] != 4'h0 ? mon[3:0] + 4'ha : mon[3:0])
			: mon[3:0];
		// Leap test on a BCD year: tens parity with units digit
		leap = bcd && (yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
			: (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8));
		case (m)
			4'h2: month_end = leap ? 8'h1d : 8'h1c; // [RULE_16]
			4'h4, 4'h6, 4'h9, 4'hb: month_end = 8'h1e;
			default: month_end = 8'h1f;
		endcase
		// Binary 28..31 becomes BCD 28..31
		if (bcd)
			month_end = (month_end >= 8'h1e) ? month_end + 8'h12
				: month_end + 8'h0c;
	endfunction

	// Source pin synchroniser and rising-edge detect on stages two/three
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i)
			src_q <= 3'h0;
		else if (clk_en_i)
			src_q <= {src_q[1:0], src_clk_i};
	end

	// Bus decode
	assign ctrl_wr = io_wr_i && io_addr_i == rtcc_pkg::ADDR_CTRL;
	assign cnt_wr = io_wr_i && unlock_q && io_addr_i >= rtcc_pkg::ADDR_SEC
		&& io_addr_i <= rtcc_pkg::ADDR_YR; // [RULE_04]
	assign src_edge = src_q[1] && !src_q[2];
	assign div_top = !clk_sel_q ? 16'(XTAL_DIV - 1)
		: (line60_q ? rtcc_pkg::DIV_60HZ : rtcc_pkg::DIV_50HZ) - 16'h0001;
	// Ticks only while locked; unlocked holds the count still
	assign sec_tick = !unlock_q && src_edge && presc_q == div_top; // [RULE_05]
	// Every enabled alarm field must equal its count
	assign match = (!aen_q[0] || aset_q.sec == cnt_q.sec)
		&& (!aen_q[1] || aset_q.min == cnt_q.min)
		&& (!aen_q[2] || aset_q.hour_units_digit == cnt_q.hour_units_digit)
		&& (!aen_q[3] || aset_q.weekday_value == cnt_q.weekday_value);

	// Control, alarm and prescaler next state
	always_comb begin
		unlock_d = unlock_q;
		clk_sel_d = clk_sel_q;
		line60_d = line60_q;
		bcd_d = bcd_q;
		aen_d = aen_q;
		aset_d = aset_q;
		alarm_d = alarm_q;
		presc_d = presc_q;
		rdata_d = rdata_q;
		// Compare one cycle after the advance, on the new counts
		cmp_d = sec_tick || (ctrl_wr && !io_wdata_i[rtcc_pkg::CTRL_UNLOCK]);
		if (ctrl_wr) begin
			unlock_d = io_wdata_i[rtcc_pkg::CTRL_UNLOCK];
			clk_sel_d = io_wdata_i[rtcc_pkg::CTRL_CLK_SEL];
			line60_d = io_wdata_i[rtcc_pkg::CTRL_LINE60];
			bcd_d = io_wdata_i[rtcc_pkg::CTRL_BCD];
			presc_d = rtcc_pkg::PRESC_RESET; // [RULE_17] [RULE_03]
		end else if (src_edge)
			presc_d = (presc_q == div_top) ? rtcc_pkg::PRESC_RESET
				: presc_q + 16'h0001;
		if (io_wr_i) begin
			case (io_addr_i)
				rtcc_pkg::ADDR_ASEC: aset_d.sec = io_wdata_i;
				rtcc_pkg::ADDR_AMIN: aset_d.min = io_wdata_i;
				rtcc_pkg::ADDR_AHRS: aset_d.hour_units_digit = io_wdata_i;
				rtcc_pkg::ADDR_ADOW: aset_d.weekday_value = io_wdata_i[3:0];
				rtcc_pkg::ADDR_AEN: aen_d = io_wdata_i[3:0];
				default: ;
			endcase
		end
		// Reading control clears the flag, but a new match wins
		if (io_rd_i && io_addr_i == rtcc_pkg::ADDR_CTRL)
			alarm_d = 1'b0;
		if (cmp_q && match && aen_q != 4'h0)
			alarm_d = 1'b1; // [RULE_15]
		if (io_rd_i) begin
			case (io_addr_i) // [RULE_07]
				rtcc_pkg::ADDR_SEC: rdata_d = cnt_q.sec;
				rtcc_pkg::ADDR_MIN: rdata_d = cnt_q.min;
				rtcc_pkg::ADDR_HRS: rdata_d = cnt_q.hour_units_digit;
				rtcc_pkg::ADDR_DOW: rdata_d = {4'h0, cnt_q.weekday_value}; // [RULE_13]
				rtcc_pkg::ADDR_DOM: rdata_d = cnt_q.monthday_units_digit;
				rtcc_pkg::ADDR_MON: rdata_d = cnt_q.mon;
				rtcc_pkg::ADDR_YR: rdata_d = cnt_q.yr;
				rtcc_pkg::ADDR_ASEC: rdata_d = aset_q.sec;
				rtcc_pkg::ADDR_AMIN: rdata_d = aset_q.min;
				rtcc_pkg::ADDR_AHRS: rdata_d = aset_q.hour_units_digit;
				rtcc_pkg::ADDR_ADOW: rdata_d = {4'h0, aset_q.weekday_value};
				rtcc_pkg::ADDR_AEN: rdata_d = {4'h0, aen_q};
				rtcc_pkg::ADDR_CTRL: rdata_d = {alarm_q, 3'h0, bcd_q,
					line60_q, clk_sel_q, unlock_q};
				default: rdata_d = 8'h00;
			endcase
		end
	end

	// Control state; set-points keep no reset value by design
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			unlock_q <= 1'b0; // [RULE_06]
			clk_sel_q <= 1'b0;
			line60_q <= 1'b0;
			bcd_q <= 1'b0;
			aen_q <= rtcc_pkg::AEN_RESET; // [RULE_01]
			alarm_q <= 1'b0;
			cmp_q <= 1'b0;
			presc_q <= rtcc_pkg::PRESC_RESET;
			rdata_q <= 8'h00;
		end else if (clk_en_i) begin
			unlock_q <= unlock_d;
			clk_sel_q <= clk_sel_d;
			line60_q <= line60_d;
			bcd_q <= bcd_d;
			aen_q <= aen_d;
			alarm_q <= alarm_d;
			cmp_q <= cmp_d;
			presc_q <= presc_d;
			rdata_q <= rdata_d;
		end
	end

	// Time count next state: CPU load when unlocked, else the carry chain
	always_comb begin
		logic [8:0] s, m, h, d, mo, y;
		logic [2:0] w;
		cnt_d = cnt_q;
		s = step(cnt_q.sec, rtcc_pkg::CNT_ZERO, bcd_q
			? rtcc_pkg::SEC_MAX_BCD : rtcc_pkg::SEC_MAX_BIN, bcd_q); // [RULE_10]
		m = step(cnt_q.min, rtcc_pkg::CNT_ZERO, bcd_q
			? rtcc_pkg::SEC_MAX_BCD : rtcc_pkg::SEC_MAX_BIN, bcd_q); // [RULE_11]
		h = step(cnt_q.hour_units_digit, rtcc_pkg::CNT_ZERO, bcd_q
			? rtcc_pkg::HRS_MAX_BCD : rtcc_pkg::HRS_MAX_BIN, bcd_q); // [RULE_12]
		d = step(cnt_q.monthday_units_digit, rtcc_pkg::CNT_ONE,
			month_end(cnt_q.mon, cnt_q.yr, bcd_q), bcd_q); // [RULE_14]
		mo = step(cnt_q.mon, rtcc_pkg::CNT_ONE, bcd_q
			? rtcc_pkg::MON_MAX_BCD : rtcc_pkg::MON_MAX_BIN, bcd_q); // [RULE_18]
		y = step(cnt_q.yr, rtcc_pkg::CNT_ZERO, bcd_q
			? rtcc_pkg::YR_MAX_BCD : rtcc_pkg::YR_MAX_BIN, bcd_q);
		w = (cnt_q.weekday_value[2:0] == rtcc_pkg::DOW_MAX[2:0]) ? 3'h1
			: cnt_q.weekday_value[2:0] + 3'h1;
		if (cnt_wr) begin
			case (io_addr_i)
				rtcc_pkg::ADDR_SEC: cnt_d.sec = io_wdata_i;
				rtcc_pkg::ADDR_MIN: cnt_d.min = io_wdata_i;
				rtcc_pkg::ADDR_HRS: cnt_d.hour_units_digit = io_wdata_i;
				rtcc_pkg::ADDR_DOW: cnt_d.weekday_value = io_wdata_i[3:0]; // [RULE_13]
				rtcc_pkg::ADDR_DOM: cnt_d.monthday_units_digit = io_wdata_i;
				rtcc_pkg::ADDR_MON: cnt_d.mon = io_wdata_i;
				default: cnt_d.yr = io_wdata_i;
			endcase
		end else if (sec_tick) begin
			cnt_d.sec = s[7:0]; // [RULE_19]
			if (s[8]) begin
				cnt_d.min = m[7:0];
				if (m[8]) begin
					cnt_d.hour_units_digit = h[7:0];
					if (h[8]) begin
						cnt_d.weekday_value = {1'b0, w};
						cnt_d.monthday_units_digit = d[7:0];
						if (d[8]) begin
							cnt_d.mon = mo[7:0];
							if (mo[8])
								cnt_d.yr = y[7:0];
						end
					end
				end
			end
		end
	end

	// Counts and set-points carry no reset: they survive a system reset
	always_ff @(posedge sys_clk_i) begin
		if (clk_en_i) begin
			cnt_q <= cnt_d; // [RULE_08]
			aset_q <= aset_d;
		end
	end

	assign io_rdata_o = rdata_q;
	assign alarm_o = alarm_q;

	chk_lock_reset: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		$past(rst_i) |-> !unlock_q && aen_q == 4'h0) // [RULE_06]
		else $error("counter not locked after reset");
	chk_frozen_unlocked: assert property (@(posedge sys_clk_i)
		disable iff (rst_i) clk_en_i && unlock_q && !cnt_wr
		|=> $stable(cnt_q)) // [RULE_04]
		else $error("count moved while unlocked");
	chk_locked_readonly: assert property (@(posedge sys_clk_i)
		disable iff (rst_i) clk_en_i && !unlock_q && !sec_tick
		|=> $stable(cnt_q)) // [RULE_05]
		else $error("locked count changed without a tick");
	chk_sec_wrap: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		clk_en_i && sec_tick && !bcd_q && cnt_q.sec == 8'h3b
		|=> cnt_q.sec == 8'h00 && cnt_q.min != $past(cnt_q.min)) // [RULE_10]
		else $error("seconds did not wrap and carry");
	chk_hour_wrap: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		clk_en_i && sec_tick && bcd_q && cnt_q.sec == 8'h59
		&& cnt_q.min == 8'h59 && cnt_q.hour_units_digit == 8'h23
		|=> cnt_q.hour_units_digit == 8'h00 && cnt_q.min == 8'h00) // [RULE_12]
		else $error("BCD hours did not wrap at 23");
	chk_dow_upper: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		clk_en_i && io_rd_i && io_addr_i == rtcc_pkg::ADDR_DOW
		|=> io_rdata_o[7:4] == 4'h0) // [RULE_13]
		else $error("weekday upper nibble not zero");
	chk_presc_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		clk_en_i && ctrl_wr |=> presc_q == 16'h0000) // [RULE_17]
		else $error("prescaler not reset by control write");
	chk_alarm_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		clk_en_i && sec_tick ##1 clk_en_i && match && aen_q != 4'h0
		|=> alarm_o) // [RULE_15]
		else $error("alarm not raised on match");
endmodule

// >>> logic/rtcc_pkg.sv
// Package for the real-time clock count core: map, fields, constants
package rtcc_pkg;
	// Byte-wide I/O locations
	localparam logic [15:0] ADDR_SEC = 16'h00e0;
	localparam logic [15:0] ADDR_MIN = 16'h00e1;
	localparam logic [15:0] ADDR_HRS = 16'h00e2;
	localparam logic [15:0] ADDR_DOW = 16'h00e3;
	localparam logic [15:0] ADDR_DOM = 16'h00e4;
	localparam logic [15:0] ADDR_MON = 16'h00e5;
	localparam logic [15:0] ADDR_YR = 16'h00e6;
	localparam logic [15:0] ADDR_ASEC = 16'h00e8;
	localparam logic [15:0] ADDR_AMIN = 16'h00e9;
	localparam logic [15:0] ADDR_AHRS = 16'h00ea;
	localparam logic [15:0] ADDR_ADOW = 16'h00eb;
	localparam logic [15:0] ADDR_AEN = 16'h00ec;
	localparam logic [15:0] ADDR_CTRL = 16'h00ed;
	// Control register fields
	localparam int CTRL_UNLOCK = 0;
	localparam int CTRL_CLK_SEL = 1;
	localparam int CTRL_LINE60 = 2;
	localparam int CTRL_BCD = 3;
	localparam int CTRL_ALARM = 7;
	// Alarm enable fields: bit order sec, min, hrs, dow
	localparam int AEN_WIDTH = 4;
	localparam logic [3:0] AEN_RESET = 4'h0;
	// Prescaler divisors, in source edges per second
	localparam int DIV_XTAL = 32768;
	localparam logic [15:0] DIV_50HZ = 16'h0032;
	localparam logic [15:0] DIV_60HZ = 16'h003c;
	localparam logic [15:0] PRESC_RESET = 16'h0000;
	// Count limits, binary then BCD
	localparam logic [7:0] SEC_MAX_BIN = 8'h3b;
	localparam logic [7:0] SEC_MAX_BCD = 8'h59;
	localparam logic [7:0] HRS_MAX_BIN = 8'h17;
	localparam logic [7:0] HRS_MAX_BCD = 8'h23;
	localparam logic [7:0] DOW_MAX = 8'h07;
	localparam logic [7:0] MON_MAX_BIN = 8'h0c;
	localparam logic [7:0] MON_MAX_BCD = 8'h12;
	localparam logic [7:0] YR_MAX_BIN = 8'h63;
	localparam logic [7:0] YR_MAX_BCD = 8'h99;
	localparam logic [7:0] CNT_ZERO = 8'h00;
	localparam logic [7:0] CNT_ONE = 8'h01;

	// Present time counts, carried as one word
	typedef struct packed {
		logic [7:0] yr;
		logic [7:0] mon;
		logic [7:0] monthday_units_digit;
		logic [3:0] weekday_value;
		logic [7:0] hour_units_digit;
		logic [7:0] min;
		logic [7:0] sec;
	} rtcc_time_type;

	// Alarm set-points
	typedef struct packed {
		logic [3:0] weekday_value;
		logic [7:0] hour_units_digit;
		logic [7:0] min;
		logic [7:0] sec;
	} rtcc_alarm_type;
endpackage

// >>> bench/rtcc_src_model.sv
// Time source model: square wave on the source pin
module rtcc_src_model #(
	parameter int HALF_NS = 300
) (
	// Run control from the bench
	input wire logic run_i,
	// Source pin toward the core
	output logic src_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Idle low like a stopped oscillator; half period well over 2 clocks
	initial begin
		src_o = 1'b0;
		forever begin
			#(HALF_NS);
			src_o = run_i ? ~src_o : 1'b0;
		end
	end
endmodule

// >>> bench/rtcc_core_tb_top.sv
// Testbench for the real-time clock count core
module rtcc_core_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic src_clk_i;
	logic src_run = 1'b0;
	logic [15:0] io_addr_i = 16'h0000;
	logic io_rd_i = 1'b0;
	logic io_wr_i = 1'b0;
	logic clk_en = 1'b1;
	logic [7:0] io_wdata_i = 8'h00;
	logic [7:0] io_rdata_o;
	logic alarm_o;
	int num_errors = 0;
	int n_compared = 0;

	// Short divider keeps one second at 24 clocks
	rtcc_core #(.XTAL_DIV(4)) dut (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .clk_en_i(clk_en),
		.src_clk_i(src_clk_i), .io_addr_i(io_addr_i), .io_rd_i(io_rd_i),
		.io_wr_i(io_wr_i), .io_wdata_i(io_wdata_i),
		.io_rdata_o(io_rdata_o), .alarm_o(alarm_o));
	rtcc_src_model #(.HALF_NS(300)) src (.run_i(src_run), .src_o(src_clk_i));

	// 10 MHz system clock
	initial begin
		forever #50 sys_clk_i = ~sys_clk_i;
	end

	task automatic tally_and_finish();
		$display("compared=%0d errors=%0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One-cycle strobes, launched just after the edge
	task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		#10;
		io_addr_i = a;
		io_wdata_i = d;
		io_wr_i = 1'b1;
		@(posedge sys_clk_i);
		#10;
		io_wr_i = 1'b0;
	endtask

	// Read data lands on the edge after the strobe
	task automatic io_rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge sys_clk_i);
		#10;
		io_addr_i = a;
		io_rd_i = 1'b1;
		@(posedge sys_clk_i);
		#10;
		io_rd_i = 1'b0;
		d = io_rdata_o;
	endtask

	task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
		logic [7:0] v;
		io_rd(a, v);
		check(v, exp);
	endtask

	// Unlock with format bits, then load the time counts
	task automatic load(input logic [7:0] c, s, m, h, dd, mo);
		io_wr(rtcc_pkg::ADDR_CTRL, c);
		io_wr(rtcc_pkg::ADDR_SEC, s);
		io_wr(rtcc_pkg::ADDR_MIN, m);
		io_wr(rtcc_pkg::ADDR_HRS, h);
		io_wr(rtcc_pkg::ADDR_DOM, dd);
		io_wr(rtcc_pkg::ADDR_MON, mo);
	endtask

	// Poll seconds until it moves, bounded, then check the rollover
	task automatic after_tick(input logic [7:0] old, s, m, h, dd, mo);
		logic [7:0] v;
		v = old;
		for (int i = 0; i < 60 && v === old; i++)
			io_rd(rtcc_pkg::ADDR_SEC, v);
		check(v, s);
		rd_chk(rtcc_pkg::ADDR_MIN, m);
		rd_chk(rtcc_pkg::ADDR_HRS, h);
		rd_chk(rtcc_pkg::ADDR_DOM, dd);
		rd_chk(rtcc_pkg::ADDR_MON, mo);
	endtask

	initial begin
		repeat (2) @(posedge sys_clk_i);
		#10;
		rst_i = 1'b0;
		src_run = 1'b1;
		rd_chk(rtcc_pkg::ADDR_CTRL, 8'h00);
		rd_chk(rtcc_pkg::ADDR_AEN, 8'h00);
		rd_chk(16'h00f0, 8'h00);
		// Binary: seconds, minutes, hours and weekday at their top, Feb 28, year 0
		load(8'h01, 8'h3b, 8'h3b, 8'h17, 8'h1c, 8'h02);
		io_wr(rtcc_pkg::ADDR_DOW, 8'hf7);
		io_wr(rtcc_pkg::ADDR_YR, 8'h00);
		rd_chk(rtcc_pkg::ADDR_DOW, 8'h07);
		repeat (60) @(posedge sys_clk_i);
		rd_chk(rtcc_pkg::ADDR_SEC, 8'h3b);
		io_wr(rtcc_pkg::ADDR_CTRL, 8'h00);
		io_wr(rtcc_pkg::ADDR_SEC, 8'h10);
		after_tick(8'h3b, 8'h00, 8'h00, 8'h00, 8'h01, 8'h03);
		rd_chk(rtcc_pkg::ADDR_DOW, 8'h01);
		// Packed decimal: Feb 28 of a leap year gains a 29th
		load(8'h09, 8'h59, 8'h59, 8'h23, 8'h28, 8'h02);
		io_wr(rtcc_pkg::ADDR_YR, 8'h04);
		io_wr(rtcc_pkg::ADDR_CTRL, 8'h08);
		after_tick(8'h59, 8'h00, 8'h00, 8'h00, 8'h29, 8'h02);
		// Month end in decimal carries into the month
		load(8'h09, 8'h59, 8'h59, 8'h23, 8'h31, 8'h01);
		io_wr(rtcc_pkg::ADDR_CTRL, 8'h08);
		after_tick(8'h59, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02);
		// Reset in mid-run leaves counts alone and relocks
		io_wr(rtcc_pkg::ADDR_CTRL, 8'h01);
		io_wr(rtcc_pkg::ADDR_SEC, 8'h2a);
		@(posedge sys_clk_i);
		#10;
		rst_i = 1'b1;
		@(posedge sys_clk_i);
		#10;
		rst_i = 1'b0;
		rd_chk(rtcc_pkg::ADDR_SEC, 8'h2a);
		rd_chk(rtcc_pkg::ADDR_CTRL, 8'h00);
		after_tick(8'h2a, 8'h2b, 8'h00, 8'h00, 8'h01, 8'h02);
		// Mains 50 Hz: one second is 50 source edges, about 300 clocks
		io_wr(rtcc_pkg::ADDR_CTRL, 8'h01);
		io_wr(rtcc_pkg::ADDR_SEC, 8'h10);
		io_wr(rtcc_pkg::ADDR_CTRL, 8'h02);
		repeat (250) @(posedge sys_clk_i);
		rd_chk(rtcc_pkg::ADDR_SEC, 8'h10);
		repeat (80) @(posedge sys_clk_i);
		rd_chk(rtcc_pkg::ADDR_SEC, 8'h11);
		// Mains 60 Hz: 60 edges, so still unmoved where 50 Hz has ticked
		io_wr(rtcc_pkg::ADDR_CTRL, 8'h06);
		repeat (300) @(posedge sys_clk_i);
		rd_chk(rtcc_pkg::ADDR_SEC, 8'h11);
		repeat (80) @(posedge sys_clk_i);
		rd_chk(rtcc_pkg::ADDR_SEC, 8'h12);
		// Seconds alarm one step ahead of the load
		io_wr(rtcc_pkg::ADDR_CTRL, 8'h01);
		io_wr(rtcc_pkg::ADDR_SEC, 8'h00);
		// A write while the enable is low must leave no trace
		clk_en = 1'b0;
		io_wr(rtcc_pkg::ADDR_SEC, 8'h33);
		clk_en = 1'b1;
		rd_chk(rtcc_pkg::ADDR_SEC, 8'h00);
		io_wr(rtcc_pkg::ADDR_ASEC, 8'h01);
		io_wr(rtcc_pkg::ADDR_AEN, 8'h01);
		io_wr(rtcc_pkg::ADDR_CTRL, 8'h00);
		check({7'h00, alarm_o}, 8'h00);
		for (int i = 0; i < 300 && alarm_o !== 1'b1; i++) begin
			@(posedge sys_clk_i);
			#10;
		end
		check({7'h00, alarm_o}, 8'h01);
		rd_chk(rtcc_pkg::ADDR_SEC, 8'h01);
		rd_chk(rtcc_pkg::ADDR_CTRL, 8'h80);
		check({7'h00, alarm_o}, 8'h00);
		tally_and_finish();
	end

	// Watchdog: the tests need well under 5000 clocks
	initial begin
		#1000000;
		num_errors++;
		tally_and_finish();
	end
endmodule
